// ==== include/tpwm_map.svh ====
/*
 * Register offsets, field positions, reset values and count limits
 * of the timer block. Assumes an 8-bit register port, byte offsets.
 */
`ifndef TPWM_MAP_SVH
`define TPWM_MAP_SVH

// =====================================================================
// Offsets
`define TPWM_TIMER_STATUS_CONTROL 8'h00
`define TPWM_COUNTER_HIGH         8'h01
`define TPWM_COUNTER_LOW          8'h02
`define TPWM_MODULUS_HIGH         8'h03
`define TPWM_MODULUS_LOW          8'h04
`define TPWM_CH_BASE              8'h05
`define TPWM_CH_STRIDE            8'h03
`define TPWM_CH_SC                2'h0
`define TPWM_CH_VH                2'h1
`define TPWM_CH_VL                2'h2

// =====================================================================
// Field positions
`define TPWM_SC_FLAG   7
`define TPWM_SC_IE     6
`define TPWM_SC_CENTRE_ALIGNED_SELECT  5

// =====================================================================
// Values
`define TPWM_CLK_OFF   2'h0
`define TPWM_CLK_BUS   2'h1
`define TPWM_CLK_FIXED 2'h2
`define TPWM_CLK_EXT   2'h3
`define TPWM_RESET_16  16'h0000
`define TPWM_MAX_16    16'hFFFF
`define TPWM_PRE_MAX   3'h7

`endif

// ==== include/tpwm_pkg.sv ====
/*
 * Types of the timer block. Assumes tpwm_map.svh for constants.
 */
package tpwm_pkg;

    typedef enum logic [1:0]
    {
        TPWM_IC   = 2'h0,
        TPWM_OC   = 2'h1,
        TPWM_EPWM = 2'h3
    } tpwm_mode_type;

    typedef struct packed
    {
        logic       flag;
        logic       ie;
        logic [1:0] mode;
        logic [1:0] els;
        logic [15:0] value;
        logic [15:0] wbuf;
        logic       got_hi;
        logic       got_lo;
        logic       pend;
        logic       rd_latched;
        logic [7:0] rd_buf;
        logic       flag_armed;
        logic       pin_sync;
        logic       pin_prev;
        logic       out;
    } tpwm_chan_type;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tpwm_bus_type;

endpackage

// ==== src/tpwm_timer.sv ====
/*
 * Timer with capture, compare and edge-aligned PWM channels.
 * Assumes an 8-bit CPU port on the bus clock, timer pins synchronous
 * except the external clock, which goes through a two-stage synchroniser.
 */
`timescale 1ns/1ps
`include "tpwm_map.svh"

// Summary of operation
// [R1] Select 10 fixed clock, 11 external clock
// [R2] External clock synchronised, at most bus quarter
// [R3] Free-running wraps FFFF to 0, sets flag
// [R4] Modulus to zero transition sets flag
// [R5] Centre mode flag at modulus turn down
// [R6] Overflow interrupt level while flag and enable
// [R7] Up counter zero to terminal then zero
// [R8] Centre mode up then down, single endpoints
// [R9] Counter write clears counter and read latch
// [R10] Mode bits choose channel function
// [R11] Active edge captures counter into value
// [R12] Capture value bytes ignore writes
// [R13] Byte read freezes other; control write clears
// [R14] Capture sets channel flag, optional interrupt
// [R15] Debug: capture latches frozen counter
// [R16] Compare match sets, clears or toggles pin
// [R17] Compare value applies after both bytes
// [R18] Compare match sets channel flag
// [R19] PWM period is modulus plus one
// [R20] Overflow drives high, compare low; inverted
// [R21] Zero gives 0 percent, above modulus 100
// [R22] PWM buffer loads at terminal minus one
// [R23] Select 00 stops, 01 bus; no side effect
// [R24] Edge bits 00 release pin; edge meaning
// [R25] Flag clears by read then zero write
// [R26] Reset clears control and channel bits
// [R27] Channel count is a parameter
module tpwm_timer
#(
    parameter int NCH = 2 // R27
)
(
    input  wire logic               i_sys_clk,   // Bus clock
    input  wire logic               i_rst,       // Sync reset, high
    input  wire logic               i_ce,        // Clock enable
    input  wire tpwm_pkg::tpwm_bus_type i_bus,   // Register request
    output logic [7:0]              o_rdata,     // Read data
    input  wire logic               i_fixed_tick,// Fixed clock pulse
    input  wire logic               i_ext_clk,   // External clock pin
    input  wire logic               i_debug,     // Debug mode active
    input  wire logic [NCH-1:0]     i_ch_pin,    // Channel pins in
    output logic [NCH-1:0]          o_ch_pin,    // Channel pins out
    output logic [NCH-1:0]          o_ch_oe,     // Channel pin enables
    output logic                    o_ovf_irq,   // Overflow interrupt
    output logic [NCH-1:0]          o_ch_irq     // Channel interrupts
);
    import tpwm_pkg::*;

    typedef struct packed
    {
        logic              flag;
        logic              flag_armed;
        logic              ie;
        logic              centre_aligned_select;
        logic [1:0]        clk_sel;
        logic [2:0]        pre;
        logic [2:0]        pre_cnt;
        logic [15:0]       cnt;
        logic              down;
        logic [15:0]       modulus;
        logic [15:0]       mod_buf;
        logic              mod_hi;
        logic              mod_lo;
        logic              cnt_latched;
        logic [7:0]        cnt_buf;
        logic [2:0]        ext_sync;
        logic [7:0]        rdata;
        tpwm_chan_type [NCH-1:0] ch;
    } tpwm_state_type;

    tpwm_state_type st;
    tpwm_state_type next_st;

    // =================================================================
    // Helpers
    function automatic logic [7:0] ch_off(input int n, input logic [1:0] r);
        ch_off = 8'(`TPWM_CH_BASE + n * `TPWM_CH_STRIDE + int'(r));
    endfunction

    function automatic logic [7:0] sc_byte(input tpwm_chan_type c);
        sc_byte = {c.flag, c.ie, c.mode, c.els, 2'h0};
    endfunction

    logic        src_tick;
    logic        tick;
    logic [15:0] term;
    logic        wrap;
    logic [15:0] cnt_next;

    always_comb
    begin
        // Sync stage 0 only feeds stage 1; edge taken from stages 1,2
        case (st.clk_sel)
            `TPWM_CLK_BUS:   src_tick = 1'b1;            // R23
            `TPWM_CLK_FIXED: src_tick = i_fixed_tick;    // R1
            `TPWM_CLK_EXT:   src_tick = st.ext_sync[1] & ~st.ext_sync[2]; // R2
            default:         src_tick = 1'b0;            // R23
        endcase
        tick = src_tick && (st.pre_cnt == st.pre);
        term = (st.modulus == `TPWM_RESET_16) ? `TPWM_MAX_16 : st.modulus;
        wrap = 1'b0;
        cnt_next = st.cnt - 16'h0001;
        if (!st.centre_aligned_select)
        begin
            wrap = (st.cnt == term);                     // R3 R4 R7
            cnt_next = wrap ? `TPWM_RESET_16 : st.cnt + 16'h0001; // R19
        end
        else if (!st.down)
        begin
            wrap = (st.cnt == term);                     // R5
            cnt_next = wrap ? st.cnt - 16'h0001 : st.cnt + 16'h0001; // R8
        end
    end

    // =================================================================
    // Next state
    always_comb
    begin
        logic [7:0] rd;
        logic       run;
        logic       edge_hit;
        logic       match;
        next_st = st;
        rd = 8'h00;
        edge_hit = 1'b0;
        match = 1'b0;
        run = tick && !i_debug;
        next_st.ext_sync = {st.ext_sync[1:0], i_ext_clk};
        if (src_tick)
            next_st.pre_cnt = (st.pre_cnt == st.pre) ? 3'h0 : st.pre_cnt + 3'h1;
        if (run)
        begin
            next_st.cnt = cnt_next;
            if (st.centre_aligned_select && wrap)
                next_st.down = 1'b1;
            if (st.centre_aligned_select && st.down && cnt_next == `TPWM_RESET_16)
                next_st.down = 1'b0;
        end

        // Register reads
        if (i_bus.rd)
        begin
            case (i_bus.addr)
                `TPWM_TIMER_STATUS_CONTROL:
                begin
                    rd = {st.flag, st.ie, st.centre_aligned_select, st.clk_sel, st.pre};
                    next_st.flag_armed = st.flag;        // R25
                end
                `TPWM_COUNTER_HIGH:
                begin
                    rd = st.cnt_latched ? st.cnt_buf : st.cnt[15:8];
                    next_st.cnt_latched = !st.cnt_latched;
                    next_st.cnt_buf = st.cnt[7:0];
                end
                `TPWM_COUNTER_LOW:
                begin
                    rd = st.cnt_latched ? st.cnt_buf : st.cnt[7:0];
                    next_st.cnt_latched = !st.cnt_latched;
                    next_st.cnt_buf = st.cnt[15:8];
                end
                `TPWM_MODULUS_HIGH: rd = st.modulus[15:8];
                `TPWM_MODULUS_LOW:  rd = st.modulus[7:0];
                default:            rd = 8'h00;
            endcase
        end

        // Register writes
        if (i_bus.wr)
        begin
            case (i_bus.addr)
                `TPWM_TIMER_STATUS_CONTROL:
                begin
                    next_st.ie = i_bus.wdata[`TPWM_SC_IE];
                    next_st.centre_aligned_select = i_bus.wdata[`TPWM_SC_CENTRE_ALIGNED_SELECT];
                    next_st.clk_sel = i_bus.wdata[4:3];  // R23
                    next_st.pre = i_bus.wdata[2:0];
                    next_st.mod_hi = 1'b0;
                    next_st.mod_lo = 1'b0;
                    if (st.flag_armed && !i_bus.wdata[`TPWM_SC_FLAG])
                        next_st.flag = 1'b0;             // R25
                    next_st.flag_armed = 1'b0;
                end
                `TPWM_COUNTER_HIGH, `TPWM_COUNTER_LOW:
                begin
                    next_st.cnt = `TPWM_RESET_16;        // R9
                    next_st.cnt_latched = 1'b0;          // R9
                    next_st.down = 1'b0;
                    next_st.pre_cnt = 3'h0;
                end
                `TPWM_MODULUS_HIGH:
                begin
                    next_st.mod_buf[15:8] = i_bus.wdata;
                    next_st.mod_hi = 1'b1;
                end
                `TPWM_MODULUS_LOW:
                begin
                    next_st.mod_buf[7:0] = i_bus.wdata;
                    next_st.mod_lo = 1'b1;
                end
                default: ;
            endcase
        end
        if (next_st.mod_hi && next_st.mod_lo)
        begin
            next_st.modulus = next_st.mod_buf;
            next_st.mod_hi = 1'b0;
            next_st.mod_lo = 1'b0;
        end
        // A new event disarms a pending clear so it is never lost
        if (run && wrap)
            {next_st.flag, next_st.flag_armed} = 2'h2;   // R3 R4 R5 R25

        // Channels
        for (int n = 0; n < NCH; n++)
        begin
            next_st.ch[n].pin_sync = i_ch_pin[n];
            next_st.ch[n].pin_prev = st.ch[n].pin_sync;
            if (i_bus.rd && i_bus.addr == ch_off(n, `TPWM_CH_SC))
            begin
                rd = sc_byte(st.ch[n]);
                next_st.ch[n].flag_armed = st.ch[n].flag;
            end
            if (i_bus.rd && (i_bus.addr == ch_off(n, `TPWM_CH_VH)
                          || i_bus.addr == ch_off(n, `TPWM_CH_VL)))
            begin
                logic hi;
                hi = (i_bus.addr == ch_off(n, `TPWM_CH_VH));
                rd = st.ch[n].rd_latched ? st.ch[n].rd_buf       // R13
                   : (hi ? st.ch[n].value[15:8] : st.ch[n].value[7:0]);
                if (st.ch[n].mode == TPWM_IC && !i_debug)
                begin
                    next_st.ch[n].rd_latched = !st.ch[n].rd_latched; // R13
                    next_st.ch[n].rd_buf =
                        hi ? st.ch[n].value[7:0] : st.ch[n].value[15:8];
                end
            end
            if (i_bus.wr && i_bus.addr == ch_off(n, `TPWM_CH_SC))
            begin
                next_st.ch[n].ie = i_bus.wdata[6];
                next_st.ch[n].mode = i_bus.wdata[5:4];   // R10
                next_st.ch[n].els = i_bus.wdata[3:2];
                next_st.ch[n].rd_latched = 1'b0;         // R13
                next_st.ch[n].got_hi = 1'b0;
                next_st.ch[n].got_lo = 1'b0;
                next_st.ch[n].pend = 1'b0;
                if (st.ch[n].flag_armed && !i_bus.wdata[7])
                    next_st.ch[n].flag = 1'b0;           // R25
                next_st.ch[n].flag_armed = 1'b0;
            end
            // Capture mode ignores value writes
            if (i_bus.wr && st.ch[n].mode != TPWM_IC)    // R12
            begin
                if (i_bus.addr == ch_off(n, `TPWM_CH_VH))
                begin
                    next_st.ch[n].wbuf[15:8] = i_bus.wdata;
                    next_st.ch[n].got_hi = 1'b1;
                end
                if (i_bus.addr == ch_off(n, `TPWM_CH_VL))
                begin
                    next_st.ch[n].wbuf[7:0] = i_bus.wdata;
                    next_st.ch[n].got_lo = 1'b1;
                end
            end
            if (next_st.ch[n].got_hi && next_st.ch[n].got_lo)
            begin
                next_st.ch[n].got_hi = 1'b0;
                next_st.ch[n].got_lo = 1'b0;
                if (st.clk_sel == `TPWM_CLK_OFF)
                    next_st.ch[n].value = next_st.ch[n].wbuf; // R17 R22
                else
                    next_st.ch[n].pend = 1'b1;
            end
            if (st.ch[n].pend && run && (st.ch[n].mode == TPWM_OC
                || (cnt_next == term && !st.centre_aligned_select)))
            begin
                next_st.ch[n].value = st.ch[n].wbuf;     // R17 R22
                next_st.ch[n].pend = 1'b0;
            end

            case (st.ch[n].els)                          // R24
                2'h1:    edge_hit = st.ch[n].pin_sync & ~st.ch[n].pin_prev;
                2'h2:    edge_hit = ~st.ch[n].pin_sync & st.ch[n].pin_prev;
                2'h3:    edge_hit = st.ch[n].pin_sync ^ st.ch[n].pin_prev;
                default: edge_hit = 1'b0;
            endcase
            match = run && (cnt_next == st.ch[n].value);
            if (!st.centre_aligned_select)
            begin
                case (st.ch[n].mode)
                    TPWM_IC:
                        if (edge_hit)
                        begin
                            next_st.ch[n].value = st.cnt; // R11 R15
                            next_st.ch[n].flag = 1'b1;    // R14
                        end
                    TPWM_OC:
                        if (match)
                        begin
                            next_st.ch[n].flag = 1'b1;    // R18
                            case (st.ch[n].els)           // R16
                                2'h1:    next_st.ch[n].out = ~st.ch[n].out;
                                2'h2:    next_st.ch[n].out = 1'b0;
                                2'h3:    next_st.ch[n].out = 1'b1;
                                default: next_st.ch[n].out = st.ch[n].out;
                            endcase
                        end
                    default:
                    begin
                        // Compare after overflow so value 0 stays idle
                        if (run && wrap)                  // R20 R21
                            next_st.ch[n].out = (st.ch[n].value != 16'h0000)
                                                ^ st.ch[n].els[0];
                        if (match && cnt_next != `TPWM_RESET_16)
                            next_st.ch[n].out = st.ch[n].els[0]; // R20
                        if (match)
                            next_st.ch[n].flag = 1'b1;
                    end
                endcase
            end
            if (!st.centre_aligned_select && ((st.ch[n].mode == TPWM_IC) ? edge_hit : match))
                next_st.ch[n].flag_armed = 1'b0;         // R25
        end
        next_st.rdata = rd;
    end

    // =================================================================
    // State register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            next_reset: st <= '0;                        // R26
        else if (i_ce)
            st <= next_st;
    end

    always_comb
    begin
        o_rdata = st.rdata;
        o_ovf_irq = st.flag && st.ie;                    // R6
        for (int n = 0; n < NCH; n++)
        begin
            o_ch_pin[n] = st.ch[n].out;
            o_ch_oe[n] = (st.ch[n].els != 2'h0) && (st.ch[n].mode != TPWM_IC);
            o_ch_irq[n] = st.ch[n].flag && st.ch[n].ie;  // R14 R18
        end
    end

    // =================================================================
    // Checks
    property p_irq_level;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_ovf_irq == (st.flag && st.ie);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq"); // R6

    property p_wrap_flag;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && tick && !i_debug && !st.centre_aligned_select && wrap) |=>
            st.flag && st.cnt == `TPWM_RESET_16;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap"); // R3

    property p_cnt_clear;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && i_bus.wr && (i_bus.addr == `TPWM_COUNTER_HIGH
            || i_bus.addr == `TPWM_COUNTER_LOW)) |=>
            st.cnt == `TPWM_RESET_16 && !st.cnt_latched;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("cnt"); // R9

    property p_stopped;
        @(posedge i_sys_clk) disable iff (i_rst)
        (st.clk_sel == `TPWM_CLK_OFF && !i_bus.wr) |=> $stable(st.cnt);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stop"); // R23

    property p_centre_turn;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && tick && !i_debug && st.centre_aligned_select && !st.down && wrap
            && !i_bus.wr) |=> st.down && st.flag;
    endproperty
    a_centre_turn: assert property (p_centre_turn) else $error("cpwm"); // R5

    property p_bottom;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && tick && !i_debug && st.centre_aligned_select && st.down && !i_bus.wr
            && st.cnt == 16'h0001) |=> !st.down && st.cnt == `TPWM_RESET_16;
    endproperty
    a_bottom: assert property (p_bottom) else $error("bottom"); // R8

endmodule

// ==== verification/tpwm_pins_model.sv ====
/*
 * Pin-side model of the timer: external counter clock source and
 * levels on the channel pins.
 * Assumes the bench resolves each pin from the design's enables and
 * calls the tasks right after a rising bus clock edge.
 */
`timescale 1ns/1ps

module tpwm_pins_model
#(
    parameter int NCH = 2
)
(
    input  wire logic           i_sys_clk,  // Bus clock
    output logic                o_ext_clk,  // External counter clock
    output logic [NCH-1:0]      o_pin       // Far-side pin levels
);
    initial
    begin
        o_ext_clk = 1'b0;
        o_pin     = '0;
    end

    // ====================
    // External clock
    // Stands still between bursts; four bus cycles a period so the
    // synchroniser never sees a faster source
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            o_ext_clk <= 1'b1;
            repeat (2) @(posedge i_sys_clk);
            o_ext_clk <= 1'b0;
            repeat (2) @(posedge i_sys_clk);
        end
    endtask

    // ====================
    // Pin levels
    task automatic set_pin(input int ch, input logic v);
        o_pin[ch] <= v;
        @(posedge i_sys_clk);
    endtask
endmodule

// ==== verification/tpwm_timer_test.sv ====
/*
 * Self-checking bench of the timer: reads queue their expectation and
 * a monitor compares the read data; pins and interrupts are compared
 * directly.
 * Assumes tpwm_pkg, tpwm_map.svh and the pin model are compiled first.
 */
`timescale 1ns/1ps
`include "tpwm_map.svh"

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED at %0t: got %h, expected %h", \
                $time, got, exp); \
        end \
    end

module tpwm_timer_test;
    import tpwm_pkg::*;

    localparam int           NCH      = 2;
    localparam tpwm_bus_type idle_req = '{8'h00, 8'h00, 1'b0, 1'b0};
    localparam logic [7:0]   a_sc     = `TPWM_TIMER_STATUS_CONTROL;
    localparam logic [7:0]   a_cnt    = `TPWM_COUNTER_HIGH;
    localparam logic [7:0]   a_modh   = `TPWM_MODULUS_HIGH;
    localparam logic [7:0]   a_modl   = `TPWM_MODULUS_LOW;

    logic               i_sys_clk  = 1'b0;
    logic               i_rst      = 1'b1;
    tpwm_bus_type       bus        = idle_req;
    logic               tick       = 1'b0;
    logic               debug      = 1'b0;
    logic [7:0]         rdata;
    logic               ext_clk;
    logic               ovf_irq;
    logic [NCH-1:0]     pin_far;
    logic [NCH-1:0]     pin_in;
    logic [NCH-1:0]     pin_out;
    logic [NCH-1:0]     pin_oe;
    logic [NCH-1:0]     ch_irq;
    logic [7:0]         exp_q[$];
    logic [7:0]         lfsr       = 8'h31;
    logic               rd_d       = 1'b0;
    int                 num_errors = 0;
    int                 num_checks = 0;

    always #2.5 i_sys_clk = ~i_sys_clk;

    // Whoever enables its driver owns the pin
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_far);

    tpwm_timer #(.NCH(NCH)) tpwm_timer_i
    (
        .i_sys_clk    (i_sys_clk),
        .i_rst        (i_rst),
        .i_ce         (1'b1),
        .i_bus        (bus),
        .o_rdata      (rdata),
        .i_fixed_tick (tick),
        .i_ext_clk    (ext_clk),
        .i_debug      (debug),
        .i_ch_pin     (pin_in),
        .o_ch_pin     (pin_out),
        .o_ch_oe      (pin_oe),
        .o_ovf_irq    (ovf_irq),
        .o_ch_irq     (ch_irq)
    );

    tpwm_pins_model #(.NCH(NCH)) tpwm_pins_model_i
    (
        .i_sys_clk    (i_sys_clk),
        .o_ext_clk    (ext_clk),
        .o_pin        (pin_far)
    );

    // ====================
    // Read monitor: data stand only in the cycle after the strobe
    always @(posedge i_sys_clk)
    begin : mon
        logic [7:0] e;
        if (rd_d && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            `CHK(rdata, e)
        end
        rd_d <= bus.rd;
    end

    // ====================
    // Tasks
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_sys_clk);
        bus <= idle_req;
        @(posedge i_sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_sys_clk);
        bus <= idle_req;
        @(posedge i_sys_clk);
    endtask

    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd(a, e[15:8]);
        rd(a + 8'h01, e[7:0]);
    endtask

    // Fixed-clock pulses, spaced so each gives exactly one count
    task automatic ticks(input int n);
        repeat (n)
        begin
            tick <= 1'b1;
            @(posedge i_sys_clk);
            tick <= 1'b0;
            repeat (2) @(posedge i_sys_clk);
        end
        repeat (3) @(posedge i_sys_clk);
    endtask

    task automatic do_reset();
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ====================
    // Watchdog, sized for the free-running wrap plus the short tests
    initial
    begin
        repeat (80000) @(posedge i_sys_clk);
        num_errors++;
        tally_and_finish();
    end

    // ====================
    // Scenarios
    initial
    begin
        logic [7:0] v;
        int         k;
        do_reset();
        rd(a_sc, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'hFF, 8'h00);
        `CHK(pin_oe, {NCH{1'b0}})
        `CHK(ovf_irq, 1'b0)
        $display("test reset done");

        wr(a_modh, 8'h00);
        wr(a_modl, 8'h03);
        wr(a_sc, 8'h50);
        ticks(3);
        rd16(a_cnt, 16'h0003);
        rd(a_sc, 8'h50);
        ticks(1);
        rd16(a_cnt, 16'h0000);
        rd(a_sc, 8'hD0);
        `CHK(ovf_irq, 1'b1)
        ticks(4);
        wr(a_sc, 8'h50);
        rd(a_sc, 8'hD0);
        wr(a_sc, 8'h50);
        rd(a_sc, 8'h50);
        `CHK(ovf_irq, 1'b0)
        wr(a_sc, 8'h10);
        ticks(4);
        rd(a_sc, 8'h90);
        `CHK(ovf_irq, 1'b0)
        ticks(2);
        wr(a_sc, 8'h00);
        rd16(a_cnt, 16'h0002);
        ticks(1);
        rd16(a_cnt, 16'h0002);
        wr(a_cnt, lfsr);
        lfsr = lfsr_next(lfsr);
        rd16(a_cnt, 16'h0000);
        $display("test modulus overflow done");

        do_reset();
        wr(a_modh, 8'h00);
        wr(a_modl, 8'h03);
        wr(a_sc, 8'h30);
        ticks(3);
        rd(a_sc, 8'h30);
        ticks(1);
        rd16(a_cnt, 16'h0002);
        rd(a_sc, 8'hB0);
        ticks(2);
        rd16(a_cnt, 16'h0000);
        ticks(1);
        rd16(a_cnt, 16'h0001);
        $display("test centre count done");

        do_reset();
        wr(a_sc, 8'h18);
        k = 3 + int'(lfsr[1:0]);
        lfsr = lfsr_next(lfsr);
        tpwm_pins_model_i.ext_pulses(k);
        repeat (6) @(posedge i_sys_clk);
        rd16(a_cnt, 16'(k));
        $display("test external clock done");

        do_reset();
        wr(a_sc, 8'h48);
        k = 0;
        while (ovf_irq !== 1'b1 && k < 70000)
        begin
            @(posedge i_sys_clk);
            k++;
        end
        `CHK(k > 65530 && k < 65540, 1'b1)
        $display("test free-running wrap done");

        for (int m = 1; m < 4; m++)
        begin
            do_reset();
            v = 8'h02 + {4'h0, lfsr[3:0]};
            lfsr = lfsr_next(lfsr);
            wr(8'h05, 8'h50 | 8'(m << 2));
            `CHK(pin_oe[0], 1'b1)
            wr(8'h06, 8'h00);
            wr(8'h07, v);
            wr(a_sc, 8'h10);
            ticks(int'(v) - 1);
            `CHK(ch_irq[0], 1'b0)
            ticks(1);
            `CHK(pin_out[0], 1'(m != 2))
            `CHK(ch_irq[0], 1'b1)
        end
        $display("test output compare done");

        do_reset();
        wr(a_modh, 8'h00);
        wr(a_modl, 8'h03);
        wr(8'h05, 8'h38);
        wr(8'h06, 8'h00);
        wr(8'h07, 8'h02);
        wr(a_sc, 8'h10);
        ticks(4);
        `CHK(pin_out[0], 1'b1)
        ticks(2);
        `CHK(pin_out[0], 1'b0)
        ticks(2);
        `CHK(pin_out[0], 1'b1)
        $display("test edge pwm done");

        do_reset();
        wr(8'h08, 8'h44);
        wr(a_sc, 8'h10);
        ticks(6);
        debug <= 1'b1;
        ticks(2);
        `CHK(ch_irq[1], 1'b0)
        tpwm_pins_model_i.set_pin(1, 1'b1);
        repeat (4) @(posedge i_sys_clk);
        `CHK(ch_irq[1], 1'b1)
        rd16(8'h09, 16'h0006);
        wr(8'h0A, lfsr);
        rd16(8'h09, 16'h0006);
        debug <= 1'b0;
        tpwm_pins_model_i.set_pin(1, 1'b0);
        $display("test input capture done");

        repeat (3) @(posedge i_sys_clk);
        tally_and_finish();
    end
endmodule
